// File: src/csta_pkg.sv
// constants and types for the common start/trip aggregator
// assumes one 50 MHz clock and an axi4-lite register master
//
// How it works
// - common start/trip is the OR of all enabled protection starts and trips.
// - a maskable set of extra inputs also drives common start.
// - a maskable set of extra inputs also drives common trip.
// - override select Normal, Start or Trip, default Normal, needs the override permit.
// - read-only condition shows Normal, Start or Trip.
// - no blocking input; protection functions suppress their own trips.
// - rising and falling edges of start and trip give four event types.
// - per event type, software chooses whether ON, OFF or both are stored.
// - cumulative start and trip counters, cleared by a reset command.
// - every event carries a time stamp before it is stored.
// - general settings are static and ignore the setting group.
// - common outputs feed output contacts and user logic directly.
package csta_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FN_EN = 8'h04;
	localparam logic [7:0] ADDR_XSTART_EN = 8'h08;
	localparam logic [7:0] ADDR_XTRIP_EN = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
	localparam logic [7:0] ADDR_START_CNT = 8'h1c;
	localparam logic [7:0] ADDR_TRIP_CNT = 8'h20;
	localparam logic [7:0] ADDR_EVT_DATA = 8'h24;
	localparam logic [7:0] ADDR_EVT_STAMP = 8'h28;
	localparam logic [7:0] ADDR_EVT_POP = 8'h2c;
	localparam logic [7:0] ADDR_CYCLE_DIV = 8'h30;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_OVR_LSB = 0;
	localparam int CTRL_STORE_LSB = 2;
	localparam int CTRL_CNT_CLR = 8;
	localparam int STAT_COND_LSB = 0;
	localparam int STAT_START = 2;
	localparam int STAT_TRIP = 3;
	localparam int STAT_PERMIT = 4;
	localparam int STAT_EVT_VALID = 5;
	localparam int STAT_EVT_OVF = 6;
	localparam int IRQ_STORED = 0;
	localparam int IRQ_OVF = 1;

	// ------------------------------------------------------------
	// reset values and counts
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'hfc;
	localparam logic [15:0] CYCLE_DIV_RESET = 16'h0031;
	localparam int AXI_RESP_OKAY = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		OVR_NORMAL,
		OVR_START,
		OVR_TRIP
	} csta_ovr_t;

	typedef enum logic [1:0] {
		EVT_START_ON,
		EVT_START_OFF,
		EVT_TRIP_ON,
		EVT_TRIP_OFF
	} csta_evt_t;

endpackage

// File: src/csta_cycle_div.sv
// program cycle divider: one-cycle tick every div+1 clocks
// assumes div is held steady by software between writes
`timescale 1ns/1ps
module csta_cycle_div (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] div,
	output logic tick
);
	logic [15:0] count;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= 16'h0000;
			tick <= 1'b0;
		end else if (count >= div) begin
			count <= 16'h0000;
			tick <= 1'b1;
		end else begin
			count <= count + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule

// File: src/csta_evt_mem.sv
// event log memory: circular buffer of stamped events
// assumes single writer and single popping reader in one clock
`timescale 1ns/1ps
module csta_evt_mem #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 34
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic pop,
	output logic [WIDTH-1:0] rd_data,
	output logic not_empty,
	output logic overflow
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("event log depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] fill;

	wire full = (fill == (AW+1)'(DEPTH));
	wire do_pop = pop && (fill != '0);
	// a full log drops the newest event so the old record survives
	wire do_wr = wr_en && (!full || do_pop);

	always_ff @(posedge aclk) begin
		if (do_wr)
			mem[wr_ptr] <= wr_data;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
			overflow <= 1'b0;
		end else begin
			if (do_wr)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_pop)
				rd_ptr <= rd_ptr + 1'b1;
			fill <= fill + (AW+1)'(do_wr) - (AW+1)'(do_pop);
			overflow <= wr_en && !do_wr;
		end
	end

	// registered read of the oldest entry
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_data <= '0;
			not_empty <= 1'b0;
		end else begin
			rd_data <= mem[do_pop ? rd_ptr + 1'b1 : rd_ptr];
			not_empty <= (fill + (AW+1)'(do_wr) - (AW+1)'(do_pop)) != '0;
		end
	end
endmodule

// File: src/csta_top.sv
// common start/trip aggregator with event log, counters and axi4-lite registers
// assumes protection inputs synchronous to aclk, override permit from general menu
`timescale 1ns/1ps
module csta_top #(
	parameter int N_FUNC = 16,
	parameter int N_EXTRA = 8,
	parameter int LOG_DEPTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [N_FUNC-1:0] fn_start,
	input wire logic [N_FUNC-1:0] fn_trip,
	input wire logic [N_EXTRA-1:0] extra_in,
	input wire logic override_permit,
	input wire logic [31:0] time_stamp,
	output logic common_start,
	output logic common_trip,
	output logic [1:0] condition,
	output logic irq,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	initial begin
		if (N_FUNC < 1 || N_FUNC > 32 || N_EXTRA < 1 || N_EXTRA > 32)
			$error("input counts must be 1 to 32");
	end

	// ------------------------------------------------------------
	// settings, static: no setting group input exists
	// ------------------------------------------------------------
	logic [7:0] ctrl;
	logic [N_FUNC-1:0] fn_en;
	logic [N_EXTRA-1:0] xstart_en;
	logic [N_EXTRA-1:0] xtrip_en;
	logic [15:0] cycle_div;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic [31:0] start_cnt;
	logic [31:0] trip_cnt;

	wire [1:0] ovr_sel = ctrl[csta_pkg::CTRL_OVR_LSB +: 2];
	wire [5:0] store_sel = ctrl[csta_pkg::CTRL_STORE_LSB +: 6];

	// ------------------------------------------------------------
	// program cycle
	// ------------------------------------------------------------
	logic tick;
	csta_cycle_div u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.div(cycle_div),
		.tick(tick)
	);

	// ------------------------------------------------------------
	// aggregation; no blocking input, suppression lives upstream
	// ------------------------------------------------------------
	wire or_start = |(fn_start & fn_en) | |(extra_in & xstart_en);
	wire or_trip = |(fn_trip & fn_en) | |(extra_in & xtrip_en);
	// an override value written while not permitted reads back but has no effect
	wire ovr_start = override_permit && ovr_sel == csta_pkg::OVR_START;
	wire ovr_trip = override_permit && ovr_sel == csta_pkg::OVR_TRIP;
	wire next_start = or_start | ovr_start;
	wire next_trip = or_trip | ovr_trip;
	wire [1:0] next_cond = next_trip ? 2'(csta_pkg::OVR_TRIP) :
		next_start ? 2'(csta_pkg::OVR_START) : 2'(csta_pkg::OVR_NORMAL);

	// outputs registered directly for contacts and user logic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			common_start <= 1'b0;
			common_trip <= 1'b0;
			condition <= 2'h0;
		end else if (tick) begin
			common_start <= next_start;
			common_trip <= next_trip;
			condition <= next_cond;
		end
	end

	// ------------------------------------------------------------
	// events
	// ------------------------------------------------------------
	wire [3:0] evt_hit;
	assign evt_hit[csta_pkg::EVT_START_ON] = tick && next_start && !common_start;
	assign evt_hit[csta_pkg::EVT_START_OFF] = tick && !next_start && common_start;
	assign evt_hit[csta_pkg::EVT_TRIP_ON] = tick && next_trip && !common_trip;
	assign evt_hit[csta_pkg::EVT_TRIP_OFF] = tick && !next_trip && common_trip;

	// store_sel[1:0] start ON/OFF, [3:2] trip ON/OFF
	wire [3:0] evt_store = evt_hit & store_sel[3:0];
	wire any_store = |evt_store;
	// start and trip events of one cycle share one log word
	wire [33:0] log_word = {evt_store, time_stamp[29:0]};

	logic pop;
	logic [33:0] log_rd;
	logic log_valid;
	logic log_ovf;
	csta_evt_mem #(.DEPTH(LOG_DEPTH), .WIDTH(34)) u_mem (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(any_store),
		.wr_data(log_word),
		.pop(pop),
		.rd_data(log_rd),
		.not_empty(log_valid),
		.overflow(log_ovf)
	);

	// ------------------------------------------------------------
	// axi4-lite write
	// ------------------------------------------------------------
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	wire wr_known = aw_addr == csta_pkg::ADDR_CTRL || aw_addr == csta_pkg::ADDR_FN_EN ||
		aw_addr == csta_pkg::ADDR_XSTART_EN || aw_addr == csta_pkg::ADDR_XTRIP_EN ||
		aw_addr == csta_pkg::ADDR_IRQ_STAT || aw_addr == csta_pkg::ADDR_IRQ_MASK ||
		aw_addr == csta_pkg::ADDR_EVT_POP || aw_addr == csta_pkg::ADDR_CYCLE_DIV;
	wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	wire [31:0] wd = w_data & wmask;
	function automatic logic wsel(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction
	wire wr_ctrl = do_write && wsel(aw_addr, csta_pkg::ADDR_CTRL);
	wire cnt_clr = wr_ctrl && wd[csta_pkg::CTRL_CNT_CLR];
	wire [1:0] irq_clr = (do_write && wsel(aw_addr, csta_pkg::ADDR_IRQ_STAT)) ? wd[1:0] : 2'h0;
	assign pop = do_write && wsel(aw_addr, csta_pkg::ADDR_EVT_POP) && wd[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= csta_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? csta_pkg::RESP_OKAY : csta_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// settings registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= csta_pkg::CTRL_RESET;
			fn_en <= '1;
			xstart_en <= '0;
			xtrip_en <= '0;
			irq_mask <= 2'h0;
			cycle_div <= csta_pkg::CYCLE_DIV_RESET;
		end else if (do_write) begin
			unique case (aw_addr)
				csta_pkg::ADDR_CTRL: ctrl <= (ctrl & ~wmask[7:0]) | wd[7:0];
				csta_pkg::ADDR_FN_EN: fn_en <= (fn_en & ~wmask[N_FUNC-1:0]) | wd[N_FUNC-1:0];
				csta_pkg::ADDR_XSTART_EN: xstart_en <= (xstart_en & ~wmask[N_EXTRA-1:0]) | wd[N_EXTRA-1:0];
				csta_pkg::ADDR_XTRIP_EN: xtrip_en <= (xtrip_en & ~wmask[N_EXTRA-1:0]) | wd[N_EXTRA-1:0];
				csta_pkg::ADDR_IRQ_MASK: irq_mask <= (irq_mask & ~wmask[1:0]) | wd[1:0];
				csta_pkg::ADDR_CYCLE_DIV: cycle_div <= (cycle_div & ~wmask[15:0]) | wd[15:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// counters and interrupt status; a new event beats a clear
	// ------------------------------------------------------------
	wire cnt_start = evt_hit[csta_pkg::EVT_START_ON];
	wire cnt_trip = evt_hit[csta_pkg::EVT_TRIP_ON];
	wire [1:0] irq_set = {log_ovf, any_store};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_cnt <= 32'h0000_0000;
			trip_cnt <= 32'h0000_0000;
			irq_stat <= 2'h0;
			irq <= 1'b0;
		end else begin
			if (cnt_clr)
				start_cnt <= {31'h0000_0000, cnt_start};
			else if (cnt_start)
				start_cnt <= start_cnt + 32'h0000_0001;
			if (cnt_clr)
				trip_cnt <= {31'h0000_0000, cnt_trip};
			else if (cnt_trip)
				trip_cnt <= trip_cnt + 32'h0000_0001;
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
			irq <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read
	// ------------------------------------------------------------
	wire [31:0] status_word = {25'h0000000, log_ovf, log_valid, override_permit,
		common_trip, common_start, condition};
	logic [31:0] rd_mux;
	logic rd_known;
	always_comb begin
		rd_known = 1'b1;
		unique case ({s_axi_araddr[7:2], 2'b00})
			csta_pkg::ADDR_CTRL: rd_mux = {24'h000000, ctrl};
			csta_pkg::ADDR_FN_EN: rd_mux = 32'(fn_en);
			csta_pkg::ADDR_XSTART_EN: rd_mux = 32'(xstart_en);
			csta_pkg::ADDR_XTRIP_EN: rd_mux = 32'(xtrip_en);
			csta_pkg::ADDR_STATUS: rd_mux = status_word;
			csta_pkg::ADDR_IRQ_STAT: rd_mux = {30'h00000000, irq_stat};
			csta_pkg::ADDR_IRQ_MASK: rd_mux = {30'h00000000, irq_mask};
			csta_pkg::ADDR_START_CNT: rd_mux = start_cnt;
			csta_pkg::ADDR_TRIP_CNT: rd_mux = trip_cnt;
			csta_pkg::ADDR_EVT_DATA: rd_mux = {28'h0000000, log_rd[33:30]};
			csta_pkg::ADDR_EVT_STAMP: rd_mux = {2'h0, log_rd[29:0]};
			csta_pkg::ADDR_CYCLE_DIV: rd_mux = {16'h0000, cycle_div};
			default: begin
				rd_mux = 32'h0000_0000;
				rd_known = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= csta_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_known ? csta_pkg::RESP_OKAY : csta_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule

// File: verif/csta_asserts.sv
// assertions on the aggregator top ports
// assumes a bind from the bench top file, one clock domain
`timescale 1ns/1ps
module csta_asserts #(
	parameter int N_FUNC = 16,
	parameter int N_EXTRA = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [N_FUNC-1:0] fn_start,
	input wire logic [N_FUNC-1:0] fn_trip,
	input wire logic [N_EXTRA-1:0] extra_in,
	input wire logic override_permit,
	input wire logic common_start,
	input wire logic common_trip,
	input wire logic [1:0] condition,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	// trip wins over start in the condition code
	a_cond_code: assert property (condition == (common_trip ? 2'h2 : {1'b0, common_start}))
		else $error("condition does not follow outputs");
	// without permit a rise needs a live source at the sampling edge
	a_start_cause: assert property ($rose(common_start) && !$past(override_permit) |-> $past(|{fn_start, extra_in}))
		else $error("common start rose without a source");
	a_trip_cause: assert property ($rose(common_trip) && !$past(override_permit) |-> $past(|{fn_trip, extra_in}))
		else $error("common trip rose without a source");
	// both halves are held one edge, the response is raised at the next
	a_wr_resp: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_b_hold: assert property (s_b_wait |=> s_axi_bvalid)
		else $error("write response dropped");
	a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_aw_shut: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write taken before response");
	a_rd_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read response dropped");
endmodule

// File: verif/csta_prot_model.sv
// protection function side: registered start, trip and extra levels
// assumes requests from the bench change just after a clock edge
`timescale 1ns/1ps
module csta_prot_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] want_start,
	input wire logic [15:0] want_trip,
	input wire logic [7:0] want_extra,
	output logic [15:0] fn_start,
	output logic [15:0] fn_trip,
	output logic [7:0] extra_in
);
	// any trip suppression lives here, never in the aggregator
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{fn_start, fn_trip, extra_in} <= '0;
		end else begin
			{fn_start, fn_trip, extra_in} <= {want_start, want_trip, want_extra};
		end
	end
endmodule

// File: verif/common_start_trip_aggregator_tb.sv
// self-checking bench for the common start/trip aggregator
// assumes the package and design modules are compiled first
`timescale 1ns/1ps
module common_start_trip_aggregator_tb;
	logic aclk, aresetn, override_permit, common_start, common_trip, irq;
	logic [15:0] want_start, want_trip, fn_start, fn_trip;
	logic [7:0] want_extra, extra_in, s_axi_awaddr, s_axi_araddr;
	logic [31:0] time_stamp, s_axi_wdata, s_axi_rdata, fe, xs, xt;
	logic [1:0] condition, s_axi_bresp, s_axi_rresp, ovr, e;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int seed = 14488;
	int n_mismatch = 0;
	int checked = 0;
	int cyc = 0;
	int ns = 0;
	int nt = 0;

	csta_top DUT (.aclk, .aresetn, .fn_start, .fn_trip, .extra_in, .override_permit, .time_stamp,
		.common_start, .common_trip, .condition, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	csta_prot_model u_prot (.aclk, .aresetn, .want_start, .want_trip, .want_extra, .fn_start, .fn_trip, .extra_in);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] x);
		checked++;
		if (got !== x) begin
			n_mismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, got, x);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata & m, x);
		chk(32'(s_axi_rresp), 32'(er));
	endtask
	function automatic logic [1:0] exp_out(input logic [1:0] ov);
		logic s, t;
		s = |(want_start & fe[15:0]) || |(want_extra & xs[7:0]) || (override_permit && ov == 2'h1);
		t = |(want_trip & fe[15:0]) || |(want_extra & xt[7:0]) || (override_permit && ov == 2'h2);
		return {t, s};
	endfunction
	task automatic outs;
		e = exp_out(ovr);
		chk({30'h0, common_trip, common_start}, {30'h0, e});
		chk({30'h0, condition}, {30'h0, e[1] ? 2'h2 : e});
	endtask
	// four program ticks at the shortened cycle, plus the input and output registers
	task automatic settle;
		repeat (18) @(posedge aclk);
	endtask

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		{want_start, want_trip, want_extra, time_stamp, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, override_permit, aresetn} = '0;
		{xs, xt, ovr} = '0;
		fe = '1;
		s_axi_wstrb = 4'hf;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(csta_pkg::ADDR_CTRL, {24'h0, csta_pkg::CTRL_RESET});
		rd(csta_pkg::ADDR_XSTART_EN, 32'h0);
		rd(csta_pkg::ADDR_XTRIP_EN, 32'h0);
		rd(csta_pkg::ADDR_CYCLE_DIV, {16'h0, csta_pkg::CYCLE_DIV_RESET});
		rd(8'h40, 32'h0, '1, csta_pkg::RESP_SLVERR);
		wr(8'h40, 32'h1, csta_pkg::RESP_SLVERR);
		wr(csta_pkg::ADDR_CYCLE_DIV, 32'h3);
		wr(csta_pkg::ADDR_CTRL, 32'h1fc);
		$display("test reset done");
		for (int i = 0; i < 24; i++) begin
			@(posedge aclk);
			{want_start, want_trip, want_extra} <= '0;
			settle();
			fe = $random(seed) & $random(seed);
			xs = $random(seed) & $random(seed);
			xt = $random(seed);
			wr(csta_pkg::ADDR_FN_EN, fe);
			wr(csta_pkg::ADDR_XSTART_EN, xs);
			wr(csta_pkg::ADDR_XTRIP_EN, xt);
			@(posedge aclk);
			want_start <= 16'($random(seed) & $random(seed));
			want_trip <= 16'($random(seed) & $random(seed));
			want_extra <= 8'($random(seed) & $random(seed));
			settle();
			outs();
			ns += e[0];
			nt += e[1];
		end
		rd(csta_pkg::ADDR_START_CNT, ns);
		rd(csta_pkg::ADDR_TRIP_CNT, nt);
		wr(csta_pkg::ADDR_CTRL, 32'h1fc);
		rd(csta_pkg::ADDR_START_CNT, 32'h0);
		$display("test random done");
		@(posedge aclk);
		{want_start, want_trip, want_extra} <= '0;
		time_stamp <= $random(seed);
		settle();
		fe = '1;
		wr(csta_pkg::ADDR_FN_EN, fe);
		// start ON is not stored, start OFF is
		wr(csta_pkg::ADDR_CTRL, 32'hf8);
		repeat (17) wr(csta_pkg::ADDR_EVT_POP, 32'h1);
		wr(csta_pkg::ADDR_IRQ_STAT, 32'h3);
		@(posedge aclk);
		want_start <= 16'h1;
		settle();
		rd(csta_pkg::ADDR_STATUS, 32'h0, 32'h20);
		@(posedge aclk);
		want_start <= 16'h0;
		settle();
		rd(csta_pkg::ADDR_EVT_DATA, 32'h1 << csta_pkg::EVT_START_OFF, 32'hf);
		rd(csta_pkg::ADDR_EVT_STAMP, time_stamp & 32'h3fffffff, 32'h3fffffff);
		chk({31'h0, irq}, 32'h0);
		wr(csta_pkg::ADDR_IRQ_MASK, 32'h1);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h1);
		wr(csta_pkg::ADDR_IRQ_STAT, 32'h1);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		$display("test log done");
		for (int i = 0; i < 6; i++) begin
			ovr = 2'(i >> 1);
			@(posedge aclk);
			override_permit <= i[0];
			wr(csta_pkg::ADDR_CTRL, {24'h0, 6'h3f, ovr});
			settle();
			outs();
			rd(csta_pkg::ADDR_CTRL, {30'h0, ovr}, 32'h3);
		end
		$display("test override done");
		tally_and_finish();
	end
endmodule

bind csta_top csta_asserts #(.N_FUNC(N_FUNC), .N_EXTRA(N_EXTRA)) u_chk (.aclk, .aresetn, .fn_start, .fn_trip,
	.extra_in, .override_permit, .common_start, .common_trip, .condition, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready);
